/* include/scrl_pkg.sv */
// Constants, register map and types of the speed command ramp limiter
package scrl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SCRL_CLK_NS        = 8;
  localparam int unsigned SCRL_TICK_NS       = 1000;
  localparam int unsigned SCRL_TICK_CYCLES   = (SCRL_TICK_NS + SCRL_CLK_NS - 1) / SCRL_CLK_NS;
  localparam logic [6:0]  SCRL_TICK_LAST     = 7'(SCRL_TICK_CYCLES - 1);
  localparam logic [9:0]  SCRL_TICKS_PER_MS  = 10'h3e8;

  // ****************************************************************
  // Scaling and limits
  // ****************************************************************
  localparam logic [15:0] SCRL_FULL_SCALE    = 16'h7fff;
  localparam logic [15:0] SCRL_TIME_MIN      = 16'h0064;
  localparam logic [15:0] SCRL_SOFT_MAX      = 16'h0bb8;
  localparam logic [15:0] SCRL_SOFT_ZONE     = 16'h0200;
  localparam logic [8:0]  SCRL_FRAC_ONE      = 9'h100;

  // ****************************************************************
  // Register indices, byte address is index times four
  // ****************************************************************
  localparam logic [4:0]  SCRL_IDX_CTRL      = 5'h00;
  localparam logic [4:0]  SCRL_IDX_FA_HI     = 5'h01;
  localparam logic [4:0]  SCRL_IDX_FA_LO     = 5'h02;
  localparam logic [4:0]  SCRL_IDX_SA        = 5'h03;
  localparam logic [4:0]  SCRL_IDX_ND_HI     = 5'h04;
  localparam logic [4:0]  SCRL_IDX_ND_LO     = 5'h05;
  localparam logic [4:0]  SCRL_IDX_FB_HI     = 5'h06;
  localparam logic [4:0]  SCRL_IDX_FB_LO     = 5'h07;
  localparam logic [4:0]  SCRL_IDX_SB        = 5'h08;
  localparam logic [4:0]  SCRL_IDX_PD        = 5'h09;
  localparam logic [4:0]  SCRL_IDX_HS        = 5'h0a;
  localparam logic [4:0]  SCRL_IDX_LS        = 5'h0b;
  localparam logic [4:0]  SCRL_IDX_SOFT      = 5'h0c;
  localparam logic [4:0]  SCRL_IDX_LIM_RISE  = 5'h0d;
  localparam logic [4:0]  SCRL_IDX_LIM_FALL  = 5'h0e;
  localparam logic [4:0]  SCRL_IDX_MAX_SPD   = 5'h0f;
  localparam logic [4:0]  SCRL_IDX_BAND      = 5'h10;
  localparam logic [4:0]  SCRL_IDX_FULL_LVL  = 5'h11;
  localparam logic [4:0]  SCRL_IDX_STATUS    = 5'h12;
  localparam logic [4:0]  SCRL_IDX_SETPOINT  = 5'h13;
  localparam int unsigned SCRL_NUM_CFG       = 18;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int unsigned SCRL_CTRL_EN_BIT   = 0;
  localparam int unsigned SCRL_STAT_CASE_POS = 16;
  localparam logic [15:0] SCRL_CFG_RST [0:SCRL_NUM_CFG-1] = '{
    16'h0001, 16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8,
    16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8, 16'h5999, 16'h2666,
    16'h0000, 16'h03e8, 16'h03e8, 16'h7fff, 16'h0200, 16'h7000};

  // ****************************************************************
  // Ramp cases, Gray coded along the usual path
  // ****************************************************************
  typedef enum logic [2:0] {
    SCRL_HOLD        = 3'b000,
    SCRL_SMALL_ACCEL = 3'b001,
    SCRL_FULL_ACCEL  = 3'b011,
    SCRL_PARTIAL     = 3'b010,
    SCRL_NEUTRAL     = 3'b110,
    SCRL_SMALL_BRAKE = 3'b111,
    SCRL_FULL_BRAKE  = 3'b101
  } scrl_case_type;

endpackage

/* src/scrl_frac_div.sv */
// Serial divider giving the speed position between the two thresholds
`timescale 1ns/1ps
module scrl_frac_div (
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Asynchronous reset, active low
  input  wire logic        start,    // Start a division
  input  wire logic [15:0] num,      // Numerator, below den
  input  wire logic [15:0] den,      // Denominator
  output logic             busy,     // Division in progress
  output logic [7:0]       frac      // num * 256 / den, last result
);
  logic [3:0]  cnt_reg;
  logic [16:0] rem_reg;
  logic [7:0]  quo_reg;
  logic [16:0] rem_dbl;
  logic        fits;

  assign rem_dbl = {rem_reg[15:0], 1'b0};
  assign fits    = rem_dbl >= {1'b0, den};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 4'h0;
      rem_reg <= 17'h00000;
      quo_reg <= 8'h00;
      busy    <= 1'b0;
      frac    <= 8'h00;
    end
    else if (!busy)
    begin
      if (start)
      begin
        rem_reg <= {1'b0, num};
        quo_reg <= 8'h00;
        cnt_reg <= 4'h8;
        busy    <= 1'b1;
      end
    end
    else
    begin
      rem_reg <= fits ? rem_dbl - {1'b0, den} : rem_dbl;
      quo_reg <= {quo_reg[6:0], fits};
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h1)
      begin
        busy <= 1'b0;
        // A zero span gives no position
        frac <= (den == 16'h0000) ? 8'h00 : {quo_reg[6:0], fits};
      end
    end
  end
endmodule // scrl_frac_div

/* src/scrl_rate_gen.sv */
// Step generator: one step per full scale over the ramp time
`timescale 1ns/1ps
module scrl_rate_gen
  import scrl_pkg::*;
(
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Asynchronous reset, active low
  input  wire logic        tick,     // One microsecond enable
  input  wire logic        restart,  // Clear the phase accumulator
  input  wire logic        run,      // Ramp is active
  input  wire logic [15:0] time_ms,  // Time for full scale, ms
  output logic             step      // One LSB step, one cycle
);
  logic [15:0] time_lim;
  logic [25:0] thr;
  logic [25:0] acc_reg;
  logic [25:0] sum;

  // Full scale per time_ms milliseconds, at most one step per tick
  assign time_lim = (time_ms < SCRL_TIME_MIN) ? SCRL_TIME_MIN : time_ms;
  assign thr      = 26'(time_lim) * 26'(SCRL_TICKS_PER_MS);
  assign sum      = acc_reg + 26'(SCRL_FULL_SCALE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 26'h0000000;
      step    <= 1'b0;
    end
    else
    begin
      step <= 1'b0;
      if (restart || !run)
        acc_reg <= 26'h0000000;
      else if (tick)
      begin
        if (sum >= thr)
        begin
          acc_reg <= sum - thr;
          step    <= 1'b1;
        end
        else
          acc_reg <= sum;
      end
    end
  end
endmodule // scrl_rate_gen

/* src/scrl_limiter.sv */
// Speed command ramp limiter with APB register file
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module scrl_limiter (
  input  wire logic        pclk,       // System clock, 125 MHz
  input  wire logic        presetn,    // Asynchronous reset, active low
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB write
  input  wire logic [31:0] pwdata,     // APB write data
  output logic [31:0]      prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  input  wire logic [15:0] throttle,   // Signed throttle, positive forward
  input  wire logic [15:0] brake,      // Brake demand, 0 to 7fff
  input  wire logic [15:0] motor_spd,  // Signed speed, 7fff is typical max
  output logic [15:0]      speed_cmd,  // Signed rate-limited speed command
  output logic [15:0]      setpoint,   // Effective maximum-speed setpoint
  output scrl_pkg::scrl_case_type ramp_case  // Active ramp case
);
  import scrl_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] mag(input logic [15:0] v);
    logic [15:0] n;
    n = 16'(~v + 16'h0001);
    if (!v[15])
      mag = v;
    else if (v == 16'h8000)
      mag = SCRL_FULL_SCALE;
    else
      mag = n;
  endfunction

  function automatic logic [15:0] blend(input logic [15:0] t_lo, input logic [15:0] t_hi,
                                        input logic [8:0] f);
    logic signed [16:0] diff;
    logic signed [26:0] prod;
    logic signed [17:0] res;
    diff  = $signed({1'b0, t_hi}) - $signed({1'b0, t_lo});
    prod  = 27'(diff) * 27'($signed({1'b0, f}));
    res   = $signed({2'b00, t_lo}) + 18'(prod >>> 8);
    blend = res[15:0];
  endfunction

  // ****************************************************************
  // Microsecond tick
  // ****************************************************************
  logic [6:0] div_reg;
  logic       tick_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg  <= 7'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == SCRL_TICK_LAST);
      div_reg  <= (div_reg == SCRL_TICK_LAST) ? 7'h00 : div_reg + 7'h01;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic [15:0] cfg_reg [0:SCRL_NUM_CFG-1];
  logic [4:0]  idx;
  logic        addr_ok;
  logic        wr_ok;
  logic        wr_take;
  logic [31:0] rd_mux;

  assign idx     = paddr[6:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && !paddr[7] && (idx <= SCRL_IDX_SETPOINT);
  assign wr_ok   = addr_ok && (idx < SCRL_IDX_STATUS);
  assign wr_take = psel && penable && pready && pwrite && wr_ok;

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (idx == SCRL_IDX_STATUS)
      rd_mux = {13'h0000, ramp_case, speed_cmd};
    else if (idx == SCRL_IDX_SETPOINT)
      rd_mux = {16'h0000, setpoint};
    else if (idx < SCRL_IDX_STATUS)
      rd_mux = {16'h0000, cfg_reg[idx]};
  end

  // Answer in the cycle after setup, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (pwrite ? !wr_ok : !addr_ok);
      prdata  <= (psel && !penable && !pwrite && addr_ok) ? rd_mux : 32'h00000000;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SCRL_NUM_CFG; gi++)
    begin : g_cfg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cfg_reg[gi] <= SCRL_CFG_RST[gi];
        else if (wr_take && (idx == 5'(gi)))
          cfg_reg[gi] <= pwdata[15:0];
      end
    end
  endgenerate

  // ****************************************************************
  // Speed zone and blend position
  // ****************************************************************
  logic [15:0] spd_abs;
  logic [15:0] hs_lvl;
  logic [15:0] ls_lvl;
  logic        zone_hi;
  logic        zone_lo;
  logic [7:0]  frac;
  logic [8:0]  pos;

  assign spd_abs = mag(motor_spd);
  assign hs_lvl  = {1'b0, cfg_reg[SCRL_IDX_HS][14:0]};
  assign ls_lvl  = {1'b0, cfg_reg[SCRL_IDX_LS][14:0]};
  assign zone_hi = spd_abs > hs_lvl;
  assign zone_lo = !zone_hi && (spd_abs < ls_lvl);

  scrl_frac_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (!zone_hi && !zone_lo),
    .num     (16'(spd_abs - ls_lvl)),
    .den     (16'(hs_lvl - ls_lvl)),
    .busy    (),
    .frac    (frac)
  );

  // Position 0 selects the low time, 256 the high time
  assign pos = zone_hi ? SCRL_FRAC_ONE : (zone_lo ? 9'h000 : {1'b0, frac});

  // ****************************************************************
  // Ramp case selection
  // ****************************************************************
  logic [15:0]        thr_abs;
  logic [15:0]        brk_lvl;
  logic [15:0]        cmd_abs;
  logic [15:0]        tgt_abs;
  logic signed [31:0] tgt_prod;
  logic [15:0]        target;
  logic               thr_full;
  logic               reversing;
  scrl_case_type      case_next;
  logic [15:0]        tgt_next;

  assign thr_abs  = mag(throttle);
  assign brk_lvl  = {1'b0, brake[14:0]};
  assign cmd_abs  = mag(speed_cmd);
  assign tgt_prod = $signed(throttle) * $signed({16'h0000, setpoint});
  assign target   = tgt_prod[30:15];
  assign tgt_abs  = mag(target);
  assign thr_full = thr_abs >= cfg_reg[SCRL_IDX_FULL_LVL];
  assign reversing = (speed_cmd != 16'h0000) && (throttle[15] != speed_cmd[15]);

  always_comb
  begin
    case_next = SCRL_HOLD;
    tgt_next  = speed_cmd;
    if (!cfg_reg[SCRL_IDX_CTRL][SCRL_CTRL_EN_BIT])
    begin
      case_next = SCRL_HOLD;
      tgt_next  = 16'h0000;
    end
    else if (brk_lvl > cfg_reg[SCRL_IDX_BAND])
    begin
      case_next = (brk_lvl >= cfg_reg[SCRL_IDX_FULL_LVL]) ? SCRL_FULL_BRAKE : SCRL_SMALL_BRAKE;
      tgt_next  = 16'h0000;
    end
    else if (thr_abs <= cfg_reg[SCRL_IDX_BAND])
    begin
      case_next = SCRL_NEUTRAL;
      tgt_next  = 16'h0000;
    end
    else if (reversing)
    begin
      case_next = thr_full ? SCRL_FULL_BRAKE : SCRL_SMALL_BRAKE;
      tgt_next  = target;
    end
    else if (tgt_abs > cmd_abs)
    begin
      case_next = thr_full ? SCRL_FULL_ACCEL : SCRL_SMALL_ACCEL;
      tgt_next  = target;
    end
    else if (tgt_abs < cmd_abs)
    begin
      case_next = SCRL_PARTIAL;
      tgt_next  = target;
    end
  end

  // ****************************************************************
  // Ramp time for the active case
  // ****************************************************************
  logic        regen_reg;
  logic [16:0] soft_sum;
  logic [15:0] soft_lim;
  logic [15:0] base_time;
  logic [15:0] case_time;

  always_comb
  begin
    case (ramp_case)
      SCRL_FULL_ACCEL:
        base_time = blend(cfg_reg[SCRL_IDX_FA_LO], cfg_reg[SCRL_IDX_FA_HI], pos);
      SCRL_SMALL_ACCEL:
        base_time = cfg_reg[SCRL_IDX_SA];
      SCRL_NEUTRAL:
        base_time = blend(cfg_reg[SCRL_IDX_ND_LO], cfg_reg[SCRL_IDX_ND_HI], pos);
      SCRL_FULL_BRAKE:
        base_time = blend(cfg_reg[SCRL_IDX_FB_LO], cfg_reg[SCRL_IDX_FB_HI], pos);
      SCRL_SMALL_BRAKE:
        base_time = cfg_reg[SCRL_IDX_SB];
      SCRL_PARTIAL:
        base_time = cfg_reg[SCRL_IDX_PD];
      default:
        base_time = SCRL_TIME_MIN;
    endcase
  end

  // Drive that follows regen braking is stretched while near zero
  assign soft_lim  = (cfg_reg[SCRL_IDX_SOFT] > SCRL_SOFT_MAX) ? SCRL_SOFT_MAX : cfg_reg[SCRL_IDX_SOFT];
  assign soft_sum  = {1'b0, base_time} + {1'b0, soft_lim};
  assign case_time = (regen_reg && cmd_abs < SCRL_SOFT_ZONE &&
                      (ramp_case == SCRL_FULL_ACCEL || ramp_case == SCRL_SMALL_ACCEL))
                     ? (soft_sum[16] ? 16'hffff : soft_sum[15:0]) : base_time;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      regen_reg <= 1'b0;
    else if (reversing && (ramp_case == SCRL_FULL_BRAKE || ramp_case == SCRL_SMALL_BRAKE))
      regen_reg <= 1'b1;
    else if (cmd_abs >= SCRL_SOFT_ZONE && !reversing)
      regen_reg <= 1'b0;
  end

  // ****************************************************************
  // Speed command ramp
  // ****************************************************************
  logic cmd_step;
  logic case_change;

  assign case_change = case_next != ramp_case;

  scrl_rate_gen u_cmd_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_reg),
    .restart (case_change),
    .run     (ramp_case != SCRL_HOLD),
    .time_ms (case_time),
    .step    (cmd_step)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_case <= SCRL_HOLD;
    else
      ramp_case <= case_next;
  end

  // One LSB toward the target per step, never past it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed_cmd <= 16'h0000;
    else if (!cfg_reg[SCRL_IDX_CTRL][SCRL_CTRL_EN_BIT])
      speed_cmd <= 16'h0000;
    else if (cmd_step && !case_change)
    begin
      if ($signed(tgt_next) > $signed(speed_cmd))
        speed_cmd <= speed_cmd + 16'h0001;
      else if ($signed(tgt_next) < $signed(speed_cmd))
        speed_cmd <= speed_cmd - 16'h0001;
    end
  end

  // ****************************************************************
  // Maximum-speed setpoint ramp
  // ****************************************************************
  logic [15:0] lim_req;
  logic        lim_up;
  logic        lim_move;
  logic        lim_dir_reg;
  logic        sp_step;

  assign lim_req  = {1'b0, cfg_reg[SCRL_IDX_MAX_SPD][14:0]};
  assign lim_up   = lim_req > setpoint;
  assign lim_move = lim_req != setpoint;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lim_dir_reg <= 1'b0;
    else
      lim_dir_reg <= lim_up;
  end

  // Constant rate, so a partial change takes its share of the full time
  scrl_rate_gen u_sp_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_reg),
    .restart (lim_up != lim_dir_reg),
    .run     (lim_move),
    .time_ms (lim_up ? cfg_reg[SCRL_IDX_LIM_RISE] : cfg_reg[SCRL_IDX_LIM_FALL]),
    .step    (sp_step)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      setpoint <= SCRL_FULL_SCALE;
    else if (sp_step && lim_move)
    begin
      if (lim_up)
        setpoint <= setpoint + 16'h0001;
      else
        setpoint <= setpoint - 16'h0001;
    end
  end

endmodule // scrl_limiter

/* tb/scrl_partner.sv */
// Throttle, brake and motor speed source
`timescale 1ns/1ps
module scrl_partner (
  input  wire logic [15:0] thr_req,   // Throttle asked
  input  wire logic [15:0] brk_req,   // Brake asked
  input  wire logic [15:0] spd_req,   // Speed asked
  input  wire logic        pclk,      // Clock
  input  wire logic        presetn,   // Reset
  output logic      [15:0] throttle,  // Throttle out
  output logic      [15:0] brake,     // Brake out
  output logic      [15:0] motor_spd  // Speed out
);
  // ****
  // Registered request outputs
  // ****
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      throttle <= 16'h0000;
      brake <= 16'h0000;
      motor_spd <= 16'h0000;
    end
    else
    begin
      throttle <= thr_req;
      brake <= brk_req;
      motor_spd <= spd_req;
    end
  end
endmodule // scrl_partner

/* tb/scrl_limiter_asserts.sv */
// Port checker of the speed command ramp limiter
`timescale 1ns/1ps
module scrl_limiter_asserts
  import scrl_pkg::*;
(
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset
  input wire logic [7:0]  paddr,     // Address
  input wire logic        psel,      // Select
  input wire logic        penable,   // Access
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic [15:0] speed_cmd, // Command
  input wire logic [15:0] setpoint,  // Setpoint
  input wire scrl_pkg::scrl_case_type ramp_case // Case
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [15:0] mag;
  logic        acc;
  logic        dec;
  assign mag = speed_cmd[15] ? 16'h0000 - speed_cmd : speed_cmd;
  assign acc = ramp_case inside {SCRL_FULL_ACCEL, SCRL_SMALL_ACCEL};
  assign dec = !acc && ramp_case != SCRL_HOLD;
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_only;
    pready |-> $past(psel && !penable);
  endproperty
  a_only: assert property (p_only) else $error("stray ready");
  property p_err;
    psel && !penable && paddr[7] |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad address accepted");
  property p_step;
    ramp_case != SCRL_HOLD |-> 16'(speed_cmd - $past(speed_cmd)) inside {16'h0000, 16'h0001, 16'hffff};
  endproperty
  a_step: assert property (p_step) else $error("command jumped");
  property p_lim;
    16'(setpoint - $past(setpoint)) inside {16'h0000, 16'h0001, 16'hffff};
  endproperty
  a_lim: assert property (p_lim) else $error("setpoint jumped");
  property p_new;
    $changed(ramp_case) && ramp_case != SCRL_HOLD |-> $stable(speed_cmd) [*8];
  endproperty
  a_new: assert property (p_new) else $error("step on case change");
  property p_up;
    acc && $past(ramp_case) == ramp_case && $changed(speed_cmd) |-> mag > $past(mag);
  endproperty
  a_up: assert property (p_up) else $error("accel shrank command");
  property p_down;
    dec && $past(ramp_case) == ramp_case && $past(speed_cmd) != 16'h0000 && $changed(speed_cmd)
      |-> mag < $past(mag);
  endproperty
  a_down: assert property (p_down) else $error("decel grew command");
  c_brk: cover property (ramp_case == SCRL_FULL_BRAKE);
  c_part: cover property (ramp_case == SCRL_PARTIAL);
  c_lim: cover property ($changed(setpoint));
endmodule // scrl_limiter_asserts
bind scrl_limiter scrl_limiter_asserts chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .speed_cmd(speed_cmd), .setpoint(setpoint), .ramp_case(ramp_case));

/* tb/scrl_limiter_test.sv */
// Self-checking bench of the speed command ramp limiter
`timescale 1ns/1ps
module scrl_limiter_test;
  import scrl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, seed = 32'h0000005f;
  logic pready, pslverr;
  logic [15:0] thr_r = 16'h0, brk_r = 16'h0, spd_r = 16'h0;
  logic [15:0] throttle, brake, motor_spd, speed_cmd, setpoint, c0;
  scrl_case_type ramp_case;
  int model [0:SCRL_NUM_CFG-1];
  int miscompares = 0, total_checks = 0, cyc_cnt = 0, d, k;
  int ix [9] = '{2, 1, 3, 4, 5, 6, 7, 8, 9};
  logic [15:0] th [9] = '{16'h7fff, 16'h7fff, 16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hf000, 16'h0001};
  logic [15:0] bk [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7fff, 16'h7fff, 16'h0000, 16'h0000};
  logic [15:0] sp [9] = '{16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h0000, 16'h0000};
  scrl_case_type cs [9] = '{SCRL_FULL_ACCEL, SCRL_FULL_ACCEL, SCRL_SMALL_ACCEL, SCRL_NEUTRAL,
    SCRL_NEUTRAL, SCRL_FULL_BRAKE, SCRL_FULL_BRAKE, SCRL_SMALL_BRAKE, SCRL_PARTIAL};
  logic [8:0] bad [4] = '{9'h050, 9'h005, 9'h148, 9'h080};
  scrl_limiter uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .throttle(throttle), .brake(brake), .motor_spd(motor_spd), .speed_cmd(speed_cmd),
    .setpoint(setpoint), .ramp_case(ramp_case));
  scrl_partner far (
    .thr_req(thr_r), .brk_req(brk_r), .spd_req(spd_r), .pclk(pclk), .presetn(presetn),
    .throttle(throttle), .brake(brake), .motor_spd(motor_spd));
  // ****
  // Tasks
  // ****
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Steps expected in 2500 cycles at 100 ms full scale, one step slack
  function automatic logic near(input int n);
    int e;
    e = 2500 / int'(SCRL_TICK_CYCLES) * int'(SCRL_FULL_SCALE) / (100 * int'(SCRL_TICKS_PER_MS));
    return n >= e - 1 && n <= e + 1;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input int i, input logic [15:0] v);
    model[i] = v;
    apb(1'b1, 8'(i * 4), {16'h0000, v});
  endtask
  task automatic rd(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    chk(rv, 32'(model[i]));
    chk(ev, 1'b0);
  endtask
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 100000)
    begin
      miscompares++;
      test_done();
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    for (int i = 0; i < SCRL_NUM_CFG; i++)
      model[i] = SCRL_CFG_RST[i];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < SCRL_NUM_CFG; i++)
      rd(i);
    for (int i = 1; i < 10; i++)
      wr(i, 16'(100 + rnd() % 29900));
    for (int i = 1; i < 10; i++)
      rd(i);
    foreach (bad[j])
    begin
      apb(bad[j][8], bad[j][7:0], 32'h1);
      chk(rv, 32'h0);
      chk(ev, 1'b1);
    end
    wr(SCRL_IDX_BAND, 16'h0000);
    k = 8 + rnd() % 8;
    for (int j = 0; j < 2; j++)
    begin
      wr(14 - j, 16'd100);
      wr(SCRL_IDX_MAX_SPD, 16'(j ? 32'h7fff : 32'h7fff - k));
      c0 = setpoint;
      repeat (2500) @(posedge pclk);
      d = int'(setpoint) - int'(c0);
      chk(near(j ? d : -d), 1'b1);
      repeat (5000) @(posedge pclk);
      chk(setpoint, 32'(model[SCRL_IDX_MAX_SPD]));
    end
    for (int i = 0; i < 9; i++)
    begin
      for (int t = 1; t < 10; t++)
        wr(t, 16'd1000);
      wr(2, 16'd100);
      thr_r <= 16'h7fff;
      brk_r <= 16'h0000;
      spd_r <= 16'h0000;
      repeat (5000) @(posedge pclk);
      wr(2, 16'd1000);
      wr(ix[i], 16'd100);
      thr_r <= th[i];
      brk_r <= bk[i];
      spd_r <= sp[i];
      repeat (3) @(posedge pclk);
      chk(ramp_case, cs[i]);
      c0 = speed_cmd;
      repeat (2500) @(posedge pclk);
      d = int'($signed(speed_cmd)) - int'($signed(c0));
      chk(near(i < 3 ? d : -d), 1'b1);
    end
    apb(1'b0, 8'(SCRL_IDX_SETPOINT * 4), 32'h0);
    chk(rv, 32'(model[SCRL_IDX_MAX_SPD]));
    chk(ev, 1'b0);
    wr(SCRL_IDX_CTRL, 16'h0000);
    repeat (3) @(posedge pclk);
    chk(speed_cmd, 32'h0);
    chk(ramp_case, SCRL_HOLD);
    apb(1'b0, 8'(SCRL_IDX_STATUS * 4), 32'h0);
    chk(rv, 32'h0);
    test_done();
  end
endmodule // scrl_limiter_test
